// >>> src/ppfs_pin_mux.sv
// Strap-selected pin function mux for the parallel-port data and C0 pins.
`timescale 1ns/1ns
module ppfs_pin_mux (
  input  wire logic                                   mclk,
  input  wire logic                                   sys_rst,
  input  wire logic                                   clkEn,
  input  wire logic                                   modeStrapPin,
  input  wire logic                                   busHolderCfg,
  input  wire logic [ppfs_pkg::DATA_W-1:0]            dataPinIn,
  output logic      [ppfs_pkg::DATA_W-1:0]            dataPinOut,
  output logic      [ppfs_pkg::DATA_W-1:0]            dataPinOe,
  output logic      [ppfs_pkg::DATA_W-1:0]            holdPinOut,
  output logic      [ppfs_pkg::DATA_W-1:0]            holdPinOe,
  input  wire logic                                   ctrlZeroPinIn,
  output logic                                        ctrlZeroPinOut,
  output logic                                        ctrlZeroPinOe,
  input  wire logic [ppfs_pkg::GPIO_HI:ppfs_pkg::GPIO_LO] gpioOut,
  input  wire logic [ppfs_pkg::GPIO_HI:ppfs_pkg::GPIO_LO] gpioDir,
  output logic      [ppfs_pkg::GPIO_HI:ppfs_pkg::GPIO_LO] gpioIn,
  input  wire logic [ppfs_pkg::HALF_W-1:0]            hostDataOut,
  input  wire logic                                   hostDataOe,
  output logic      [ppfs_pkg::HALF_W-1:0]            hostDataIn,
  output logic                                        hostNonMuxMode,
  input  wire logic [ppfs_pkg::DATA_W-1:0]            memDataOut,
  input  wire logic                                   memDataOe,
  output logic      [ppfs_pkg::DATA_W-1:0]            memDataIn,
  input  wire logic                                   memReadStrobe,
  output logic                                        memMode,
  output logic                                        holderEnabled
);
  import ppfs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic                            strapSync;
  logic [PIN_SYNC_W-1:0]           pinSync;
  ppfs_mode_t                      modeSel_q;
  ppfs_phase_t                     phase_q;
  logic [DATA_W-1:0]               dataOut_d;
  logic [DATA_W-1:0]               dataOe_d;
  logic                            ctrlOut_d;
  logic                            ctrlOe_d;
  logic [GPIO_HI:GPIO_LO]          gpioIn_d;
  logic [HALF_W-1:0]               hostIn_d;
  logic [DATA_W-1:0]               hostWord_d;
  logic [DATA_W-1:0]               memIn_d;

  // Passes a word only when the chosen mode owns the pins.
  function automatic logic [DATA_W-1:0] ownedBy(
    input ppfs_mode_t        sel,
    input ppfs_mode_t        owner,
    input logic [DATA_W-1:0] val
  );
    ownedBy = (sel == owner) ? val : '0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers and holders.

  ppfs_sync2 #(.WIDTH(1)) strapSyncInst (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .asyncIn (modeStrapPin),
    .syncOut (strapSync)
  );

  ppfs_sync2 #(.WIDTH(PIN_SYNC_W)) pinSyncInst (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .asyncIn ({ctrlZeroPinIn, dataPinIn}),
    .syncOut (pinSync)
  );

  ppfs_bus_holder #(.WIDTH(DATA_W)) holderInst (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .clkEn      (clkEn),
    .holdEnable (holderEnabled),
    .driveOeD   (dataOe_d),
    .pinLevel   (pinSync[DATA_W-1:0]),
    .holdOut    (holdPinOut),
    .holdOe     (holdPinOe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Strap latch and phase.

  // The strap is sampled on every reset cycle, so the value seen on the
  // last edge with reset still high wins; afterwards the pin is never looked at again.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (sys_rst) begin
        modeSel_q <= ppfs_mode_t'(strapSync);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (sys_rst) begin
        phase_q <= PPFS_PH_RESET;
      end else begin
        phase_q <= PPFS_PH_RUN;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (sys_rst) begin
        holderEnabled <= HOLDER_EN_RST;
      end else begin
        holderEnabled <= busHolderCfg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (sys_rst) begin
        hostNonMuxMode <= 1'b0;
        memMode        <= 1'b0;
      end else begin
        hostNonMuxMode <= (modeSel_q == PPFS_MODE_HOST);
        memMode        <= (modeSel_q == PPFS_MODE_MEM);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output routing.

  always_comb begin
    dataOut_d = '0;
    dataOe_d  = '0;
    ctrlOut_d = 1'b0;
    ctrlOe_d  = 1'b0;
    if (!sys_rst) begin
      unique case (modeSel_q)
        PPFS_MODE_HOST: begin
          dataOut_d[UPPER_HI:UPPER_LO] = gpioOut[GPIO_UP_HI:GPIO_LO];
          dataOe_d[UPPER_HI:UPPER_LO]  = gpioDir[GPIO_UP_HI:GPIO_LO];
          dataOut_d[LOWER_HI:0]        = hostDataOut;
          dataOe_d[LOWER_HI:0]         = {HALF_W{hostDataOe}};
          ctrlOut_d                    = gpioOut[GPIO_CTRL];
          ctrlOe_d                     = gpioDir[GPIO_CTRL];
        end
        PPFS_MODE_MEM: begin
          dataOut_d = memDataOut;
          dataOe_d  = {DATA_W{memDataOe}};
          ctrlOut_d = memReadStrobe;
          ctrlOe_d  = 1'b1;
        end
      endcase
      // On the release edge every data pin and the GPIO C0 pin come up as
      // inputs whatever the outside logic asks, so nothing fights the bus
      // before software has set directions.
      if (phase_q == PPFS_PH_RESET) begin
        dataOe_d  = '0;
        ctrlOut_d = CTRL0_MEM_IDLE;
        ctrlOe_d  = (modeSel_q == PPFS_MODE_MEM);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      dataPinOut     <= dataOut_d;
      dataPinOe      <= dataOe_d;
      ctrlZeroPinOut <= ctrlOut_d;
      ctrlZeroPinOe  <= ctrlOe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input routing.

  always_comb begin
    gpioIn_d = '0;
    if (!sys_rst && modeSel_q == PPFS_MODE_HOST) begin
      gpioIn_d = {pinSync[CTRL_SYNC], pinSync[UPPER_HI:UPPER_LO]};
    end
    hostWord_d = ownedBy(modeSel_q, PPFS_MODE_HOST, pinSync[DATA_W-1:0]);
    hostIn_d   = hostWord_d[LOWER_HI:0];
    memIn_d    = ownedBy(modeSel_q, PPFS_MODE_MEM, pinSync[DATA_W-1:0]);
  end

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (sys_rst) begin
        gpioIn     <= '0;
        hostDataIn <= '0;
        memDataIn  <= '0;
      end else begin
        gpioIn     <= gpioIn_d;
        hostDataIn <= hostIn_d;
        memDataIn  <= memIn_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_HOST_UPPER_GPIO: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && modeSel_q == PPFS_MODE_HOST && phase_q == PPFS_PH_RUN
    |=> dataPinOut[31:16] == $past(gpioOut[19:4])
        && dataPinOe[31:16] == $past(gpioDir[19:4]))
    else $error("Upper pins do not follow GPIO in host mode.");

  AST_GPIO_UP_INPUT: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RESET && modeSel_q == PPFS_MODE_HOST
    |=> dataPinOe[31:16] == 16'h0000)
    else $error("Upper GPIO pins driven after reset.");

  AST_MEM_UPPER: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && modeSel_q == PPFS_MODE_MEM && phase_q == PPFS_PH_RUN
    |=> dataPinOut[31:16] == $past(memDataOut[31:16]))
    else $error("Upper pins do not carry memory data.");

  AST_MEM_UP_INPUT: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RESET && modeSel_q == PPFS_MODE_MEM
    |=> dataPinOe[31:16] == 16'h0000)
    else $error("Upper memory data driven after reset.");

  AST_LOWER_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RUN
    |=> dataPinOut[15:0] == (memMode ? $past(memDataOut[15:0])
                                     : $past(hostDataOut)))
    else $error("Lower pins carry the wrong source.");

  // Three reset edges first, so the strap has filled both sync stages.
  AST_MODE_LATCH: assert property (@(posedge mclk)
    (clkEn && sys_rst) [*3] |=> modeSel_q == $past(strapSync))
    else $error("Strap not captured during reset.");

  AST_HOLDER_RESET: assert property (@(posedge mclk)
    clkEn && sys_rst ##1 clkEn && !sys_rst |=> holderEnabled
      == $past(busHolderCfg))
    else $error("Holder enable not restored or not following config.");

  AST_NONMUX_MODE: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RUN
    |=> hostNonMuxMode == (modeSel_q == PPFS_MODE_HOST)
        && hostNonMuxMode != memMode)
    else $error("Non-multiplexed flag wrong.");

  AST_HOST_LOWER_INPUT: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RESET && modeSel_q == PPFS_MODE_HOST
    |=> dataPinOe[15:0] == 16'h0000)
    else $error("Host data driven after reset.");

  AST_MEM_LOWER_INPUT: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RESET && modeSel_q == PPFS_MODE_MEM
    |=> dataPinOe[15:0] == 16'h0000)
    else $error("Lower memory data driven after reset.");

  AST_CTRL0_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RUN
    |=> ctrlZeroPinOut == (memMode ? $past(memReadStrobe)
                                   : $past(gpioOut[20])))
    else $error("C0 carries the wrong source.");

  AST_HOLDER_NO_FIGHT: assert property (@(posedge mclk) disable iff (sys_rst)
    (holdPinOe & dataPinOe) == 32'h00000000)
    else $error("Holder drives a pin the mux drives.");

  AST_GPIO20_INPUT: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && phase_q == PPFS_PH_RESET && modeSel_q == PPFS_MODE_HOST
    |=> !ctrlZeroPinOe)
    else $error("GPIO bit 20 driven after reset.");

  AST_CTRL0_MEM_ONE: assert property (@(posedge mclk)
    clkEn && sys_rst ##1 clkEn && !sys_rst && modeSel_q == PPFS_MODE_MEM
    |=> ctrlZeroPinOe && ctrlZeroPinOut)
    else $error("Memory C0 not driving one after reset.");

  AST_CTRL0_RESET_Z: assert property (@(posedge mclk)
    clkEn && sys_rst |=> !ctrlZeroPinOe && dataPinOe == 32'h00000000)
    else $error("Pins driven during reset.");

  AST_MODE_HOLD: assert property (@(posedge mclk)
    !sys_rst |=> sys_rst || $stable(modeSel_q))
    else $error("Latched mode changed out of reset.");

endmodule

// >>> inc/ppfs_pkg.sv
// Constants and types shared by the parallel-port pin-function select block.
package ppfs_pkg;

  // Pin group widths and general-purpose I/O bit positions.
  localparam int DATA_W     = 32;
  localparam int HALF_W     = 16;
  localparam int UPPER_LO   = 16;
  localparam int UPPER_HI   = 31;
  localparam int LOWER_HI   = 15;
  localparam int GPIO_LO    = 4;
  localparam int GPIO_HI    = 20;
  localparam int GPIO_UP_HI = 19;
  localparam int GPIO_CTRL  = 20;
  localparam int PIN_SYNC_W = 33;
  localparam int CTRL_SYNC  = 32;

  // Reset values.
  localparam logic HOLDER_EN_RST  = 1'b1;
  localparam logic CTRL0_MEM_IDLE = 1'b1;
  localparam logic SYNC_RST       = 1'b0;

  // Pin function chosen by the strap, latched while reset is held.
  typedef enum logic {
    PPFS_MODE_HOST = 1'b0,
    PPFS_MODE_MEM  = 1'b1
  } ppfs_mode_t;

  // Whether the first cycle after reset release has passed.
  typedef enum logic {
    PPFS_PH_RESET = 1'b0,
    PPFS_PH_RUN   = 1'b1
  } ppfs_phase_t;

endpackage

// >>> src/ppfs_sync2.sv
// Two-stage synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/1ns
module ppfs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import ppfs_pkg::*;

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage. Neither stage is reset.
  // The strap must travel through both while reset is held, and a reset
  // stage would hand the latch nothing but its reset level. The reset
  // port stays so that every block here is hooked up the same way.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// >>> src/ppfs_bus_holder.sv
// Bus holders that keep undriven data pins at their last level.
`timescale 1ns/1ns
module ppfs_bus_holder #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic             holdEnable,
  input  wire logic [WIDTH-1:0] driveOeD,
  input  wire logic [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] holdOut,
  output logic      [WIDTH-1:0] holdOe
);
  import ppfs_pkg::*;

  // The keeper follows the synchronised pin, so whatever party drove the
  // pin last, that level is what the holder keeps once the pin floats.
  // Its value settles three cycles after the pin, a fair price for a keeper.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (sys_rst) begin
        holdOut <= '0;
        holdOe  <= '0;
      end else begin
        holdOut <= pinLevel;
        holdOe  <= {WIDTH{holdEnable}} & ~driveOeD;
      end
    end
  end

endmodule

// >>> sim/ppfs_pin_partner.sv
// Far-side model: host or memory devices sharing the data and C0 pins.
`timescale 1ns/1ns
module ppfs_pin_partner
  import ppfs_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic [ppfs_pkg::DATA_W-1:0] dataPinOut,
  input  wire logic [ppfs_pkg::DATA_W-1:0] dataPinOe,
  input  wire logic [ppfs_pkg::DATA_W-1:0] holdPinOut,
  input  wire logic [ppfs_pkg::DATA_W-1:0] holdPinOe,
  input  wire logic                        ctrlZeroPinOut,
  input  wire logic                        ctrlZeroPinOe,
  input  wire logic [ppfs_pkg::DATA_W-1:0] farOe,
  input  wire logic [ppfs_pkg::DATA_W-1:0] farVal,
  input  wire logic                        farC0Oe,
  input  wire logic                        farC0Val,
  output logic      [ppfs_pkg::DATA_W-1:0] pinLevel,
  output logic                             c0Level
);
  ////////////////////////////////////////////////////////////////////////////
  // A pin nobody drives toggles, so a stale level can never look like a hold.
  logic floatLvl_q = 1'b0;

  always_ff @(posedge mclk) begin
    floatLvl_q <= ~floatLvl_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strong drivers win over the weak keeper; the host sends whole words.
  always_comb begin
    for (int b = 0; b < DATA_W; b++) begin
      if (dataPinOe[b])
        pinLevel[b] = dataPinOut[b];
      else if (farOe[b])
        pinLevel[b] = farVal[b];
      else if (holdPinOe[b])
        pinLevel[b] = holdPinOut[b];
      else
        pinLevel[b] = floatLvl_q;
    end
    if (ctrlZeroPinOe)
      c0Level = ctrlZeroPinOut;
    else if (farC0Oe)
      c0Level = farC0Val;
    else
      c0Level = floatLvl_q;
  end
endmodule

// >>> sim/ppfs_pin_mux_test.sv
// Self-checking bench for the strap-selected parallel-port pin mux.
`timescale 1ns/1ns
module ppfs_pin_mux_test;
  import ppfs_pkg::*;

  logic        mclk = 1'b0;
  logic        sys_rst, modeStrapPin, busHolderCfg, ctrlZeroPinIn;
  logic [31:0] dataPinIn, dataPinOut, dataPinOe, holdPinOut, holdPinOe;
  logic        ctrlZeroPinOut, ctrlZeroPinOe, hostDataOe, hostNonMuxMode;
  logic [20:4] gpioOut, gpioDir, gpioIn;
  logic [15:0] hostDataOut, hostDataIn;
  logic [31:0] memDataOut, memDataIn, farOe, farVal;
  logic        memDataOe, memReadStrobe, memMode, holderEnabled;
  logic        farC0Oe, farC0Val, clkEn;
  int          fails, checked, cycleCount;

  always #10 mclk = ~mclk;

  ppfs_pin_mux i_ppfs_pin_mux (
    .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
    .modeStrapPin(modeStrapPin), .busHolderCfg(busHolderCfg),
    .dataPinIn(dataPinIn), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
    .holdPinOut(holdPinOut), .holdPinOe(holdPinOe),
    .ctrlZeroPinIn(ctrlZeroPinIn), .ctrlZeroPinOut(ctrlZeroPinOut),
    .ctrlZeroPinOe(ctrlZeroPinOe), .gpioOut(gpioOut), .gpioDir(gpioDir),
    .gpioIn(gpioIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .hostDataIn(hostDataIn), .hostNonMuxMode(hostNonMuxMode),
    .memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn),
    .memReadStrobe(memReadStrobe), .memMode(memMode),
    .holderEnabled(holderEnabled)
  );

  ppfs_pin_partner i_ppfs_pin_partner (
    .mclk(mclk), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
    .holdPinOut(holdPinOut), .holdPinOe(holdPinOe),
    .ctrlZeroPinOut(ctrlZeroPinOut), .ctrlZeroPinOe(ctrlZeroPinOe),
    .farOe(farOe), .farVal(farVal), .farC0Oe(farC0Oe),
    .farC0Val(farC0Val), .pinLevel(dataPinIn), .c0Level(ctrlZeroPinIn)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  // The whole run needs under a hundred cycles; this limit catches a hang.
  always @(posedge mclk) begin
    cycleCount++;
    if (cycleCount == 2000) begin
      fails++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sources are asked to drive during reset; release must still float them.
  task automatic do_reset(input logic strap);
    @(negedge mclk);
    sys_rst = 1'b1;
    modeStrapPin = strap;
    busHolderCfg = 1'b0;
    gpioDir = '1;
    hostDataOe = 1'b1;
    memDataOe = 1'b1;
    farOe = '0;
    farC0Oe = 1'b0;
    repeat (5) @(negedge mclk);
    cmp(32'(ctrlZeroPinOe), 32'H0, "C0 floats in reset");
    cmp(32'(holderEnabled), 32'H1, "keeper on in reset");
    cmp(dataPinOe, 32'H0, "pins float in reset");
    sys_rst = 1'b0;
    busHolderCfg = 1'b1;
    @(posedge mclk);
    #1;
    cmp(dataPinOe, 32'H0, "pins input at release");
    cmp(32'(ctrlZeroPinOe), 32'(strap), "C0 enable at release");
    cmp(32'(ctrlZeroPinOut), 32'(CTRL0_MEM_IDLE), "C0 value at release");
    cmp(32'(memMode), 32'(strap), "memory mode flag");
    cmp(32'(hostNonMuxMode), 32'(!strap), "host mode flag");
    @(negedge mclk);
    gpioDir = '0;
    hostDataOe = 1'b0;
    memDataOe = 1'b0;
  endtask

  task automatic host_drive();
    @(negedge mclk);
    gpioOut = 17'H15A3C;
    gpioDir = '1;
    hostDataOut = 16'HC35A;
    hostDataOe = 1'b1;
    memDataOut = 32'HFFFFFFFF;
    memDataOe = 1'b1;
    @(posedge mclk);
    #1;
    cmp(dataPinOut, 32'H5A3CC35A, "host pin values");
    cmp(dataPinOe, 32'HFFFFFFFF, "host pin enables");
    cmp(32'(ctrlZeroPinOut), 32'H1, "C0 from gpio");
    cmp(32'(ctrlZeroPinOe), 32'H1, "C0 gpio enable");
    cmp(holdPinOe, 32'H0, "keeper off while driven");
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    gpioDir = '0;
    hostDataOe = 1'b0;
    memDataOe = 1'b0;
    @(posedge mclk);
    #1;
    cmp(dataPinOe, 32'H0, "host release");
    cmp(holdPinOe, 32'HFFFFFFFF, "keeper takes over");
    repeat (5) @(posedge mclk);
    #1;
    cmp(holdPinOut, 32'H5A3CC35A, "keeper holds last drive");
    cmp(32'(hostDataIn), 32'HC35A, "held level read back");
  endtask

  task automatic host_receive();
    @(negedge mclk);
    farOe = '1;
    farVal = 32'H9E1764B2;
    farC0Oe = 1'b1;
    farC0Val = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    cmp(32'(gpioIn), 32'H19E17, "gpio inputs");
    cmp(32'(hostDataIn), 32'H64B2, "host word in");
    cmp(memDataIn, 32'H0, "memory side idle");
    @(negedge mclk);
    farOe = '0;
    farC0Oe = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    cmp(holdPinOut, 32'H9E1764B2, "keeper holds far level");
    @(negedge mclk);
    busHolderCfg = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    cmp(32'(holderEnabled), 32'H0, "keeper disabled");
    cmp(holdPinOe, 32'H0, "keeper released");
    @(negedge mclk);
    busHolderCfg = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    cmp(holdPinOe, 32'HFFFFFFFF, "keeper enabled again");
  endtask

  task automatic strap_ignore();
    @(negedge mclk);
    modeStrapPin = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    cmp(32'(hostNonMuxMode), 32'H1, "strap ignored host");
    cmp(32'(memMode), 32'H0, "strap ignored memory");
  endtask

  // A low enable must freeze every flop, pins and mode flags alike.
  task automatic freeze_hold();
    @(negedge mclk);
    clkEn = 1'b0;
    gpioOut = 17'H00000;
    repeat (3) @(posedge mclk);
    #1;
    cmp(dataPinOut, 32'H5A3CC35A, "pins frozen by enable");
    cmp(32'(hostNonMuxMode), 32'H1, "mode frozen by enable");
    @(negedge mclk);
    clkEn = 1'b1;
    @(posedge mclk);
    #1;
    cmp(dataPinOut, 32'H0000C35A, "pins follow after enable");
  endtask

  task automatic mem_traffic();
    @(negedge mclk);
    memDataOut = 32'H3C96E10F;
    memDataOe = 1'b1;
    memReadStrobe = 1'b0;
    gpioDir = '1;
    hostDataOe = 1'b1;
    @(posedge mclk);
    #1;
    cmp(dataPinOut, 32'H3C96E10F, "memory pin values");
    cmp(dataPinOe, 32'HFFFFFFFF, "memory pin enables");
    cmp(32'(ctrlZeroPinOut), 32'H0, "C0 read strobe");
    @(negedge mclk);
    memDataOe = 1'b0;
    gpioDir = '0;
    hostDataOe = 1'b0;
    farOe = '1;
    farVal = 32'H5B0DA7E4;
    repeat (4) @(posedge mclk);
    #1;
    cmp(memDataIn, 32'H5B0DA7E4, "memory data in");
    cmp(32'(gpioIn), 32'H0, "gpio idle in memory mode");
    cmp(32'(hostDataIn), 32'H0, "host idle in memory mode");
    cmp(32'(ctrlZeroPinOe), 32'H1, "C0 stays output");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    checked = 0;
    cycleCount = 0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    modeStrapPin = 1'b0;
    busHolderCfg = 1'b1;
    gpioOut = '0;
    gpioDir = '0;
    hostDataOut = '0;
    hostDataOe = 1'b0;
    memDataOut = '0;
    memDataOe = 1'b0;
    memReadStrobe = 1'b0;
    farOe = '0;
    farVal = '0;
    farC0Oe = 1'b0;
    farC0Val = 1'b0;
    do_reset(1'b0);
    host_drive();
    host_receive();
    strap_ignore();
    freeze_hold();
    do_reset(1'b1);
    mem_traffic();
    close_out();
  end
endmodule
